// ===== shared/mmsc_consts.svh
// offsets, field positions, reset values and clock divider counts of the serial channel
// assumes an apb slave with 32-bit data and one aligned word per register
`ifndef MMSC_CONSTS_SVH
`define MMSC_CONSTS_SVH
`define MMSC_OFF_MODE      12'h000
`define MMSC_OFF_SHIFT     12'h004
`define MMSC_OFF_SVA       12'h008
`define MMSC_OFF_CTRL      12'h00c
`define MMSC_OFF_BITS      12'h010
`define MMSC_MODE_RESET    8'h00
`define MMSC_B_MODE0       2
`define MMSC_B_MODE1       3
`define MMSC_B_PINSEL      4
`define MMSC_B_WAKE        5
`define MMSC_B_MATCH       6
`define MMSC_B_ENABLE      7
`define MMSC_C_DONE        0
`define MMSC_C_BUSYEN      1
`define MMSC_C_LSBF        2
`define MMSC_C_FCLK        3
`define MMSC_C_FDAT        4
`define MMSC_C_ACTIVE      5
`define MMSC_C_BUSY        6
`define MMSC_DIV16_HALF    4'h7
`define MMSC_DIV8_HALF     4'h3
`define MMSC_LAST_BIT      3'h7
`endif

// ===== shared/mmsc_pkg.sv
// types of the serial channel: operating modes and clock sources
// constants live in mmsc_consts.svh
package mmsc_pkg;
  typedef enum logic [1:0] {
    MMSC_HALT,
    MMSC_THREE_WIRE,
    MMSC_BUS,
    MMSC_TWO_WIRE
  } mmsc_mode_t;
  typedef enum logic [1:0] {
    MMSC_CLK_EXT,
    MMSC_CLK_TIMER,
    MMSC_CLK_DIV16,
    MMSC_CLK_DIV8
  } mmsc_clk_t;
endpackage : mmsc_pkg

// ===== core/mmsc_channel.sv
// multimode clocked serial channel zero with apb register access
// assumes all pin inputs are asynchronous; timer toggle input is on i_ref_clk
// Behaviour
// - four modes: halt, three-wire, two-wire and addressed bus mode
// - three-wire shifts 8 bits full duplex on clock, out and in lines
// - three-wire order selectable msb/lsb first; other modes msb first
// - two-wire uses one open-drain data line; software forces both line levels
// - bus mode receiver compares every received byte with the slave address in hardware
// - mode control register resets to all zero
// - top three control bits writable singly; bit 6 ignores writes
// - clock select: external, timer toggle, fx/16, fx/8; internal drives clock pin
// - mode bits pick three-wire, bus or two-wire and the open-drain data pin
// - wake clear: done request after every transfer
// - wake set in bus mode: line released, done only on address match
// - wake does not end busy; busy ends at next falling clock after release
// - address match flag reads slave address equal to shift register
// - match flag valid only outside a transfer
// - whole-register write leaves the match flag unaffected
// - enable clear stops shifting, clears counter, holds flag, pins to port
// - enable clear means halt whatever the mode bits
`timescale 1ns/1ps
`include "mmsc_consts.svh"
module mmsc_channel (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_timer_toggle_output,
  input  wire logic        i_shift_clock_pin,
  output logic             o_shift_clock_pin,
  output logic             o_shift_clock_pin_oe,
  output logic             o_serial_out_pin,
  output logic             o_serial_out_pin_oe,
  input  wire logic        i_serial_in_pin,
  input  wire logic        i_bus_data_line_a,
  output logic             o_bus_data_line_a,
  output logic             o_bus_data_line_a_oe,
  input  wire logic        i_bus_data_line_b,
  output logic             o_bus_data_line_b,
  output logic             o_bus_data_line_b_oe,
  output logic             o_pins_to_port,
  output logic             o_transfer_done_request
);
  typedef struct packed {
    logic [7:0]  mode;
    logic [7:0]  sreg;
    logic [7:0]  slave_address_reg;
    logic        done;
    logic        busy_en;
    logic        lsb_first;
    logic        force_clk_lo;
    logic        force_dat_lo;
    logic        busy;
    logic        active;
    logic [2:0]  cnt;
    logic [3:0]  div;
    logic        sck_lvl;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic        sck_prev;
    logic        tmr_prev;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
  } mmsc_state_t;

  mmsc_state_t st_reg;
  mmsc_state_t st_next;

  mmsc_pkg::mmsc_mode_t mode_now;
  mmsc_pkg::mmsc_clk_t  clk_sel;
  logic       enabled;
  logic       internal_clk;
  logic       tick;
  logic       rise_evt;
  logic       fall_evt;
  logic       in_bit;
  logic       out_bit;
  logic       addr_match;
  logic       shifted_match;
  logic       setup;
  logic       wr_acc;
  logic       mapped;
  logic [3:0] half;
  logic [7:0] shifted;

  // halt whenever enable is clear, mode bits ignored
  always_comb
  begin
    enabled = st_reg.mode[`MMSC_B_ENABLE];
    clk_sel = mmsc_pkg::mmsc_clk_t'(st_reg.mode[1:0]);
    if (!enabled)
      mode_now = mmsc_pkg::MMSC_HALT;
    else if (!st_reg.mode[`MMSC_B_MODE1])
      mode_now = mmsc_pkg::MMSC_THREE_WIRE;
    else if (!st_reg.mode[`MMSC_B_MODE0])
      mode_now = mmsc_pkg::MMSC_BUS;
    else
      mode_now = mmsc_pkg::MMSC_TWO_WIRE;
  end

  // shift clock sources; synchronised sck pin for the external case
  always_comb
  begin
    internal_clk = (clk_sel != mmsc_pkg::MMSC_CLK_EXT);
    half = (clk_sel == mmsc_pkg::MMSC_CLK_DIV16) ? `MMSC_DIV16_HALF : `MMSC_DIV8_HALF;
    unique case (clk_sel)
      mmsc_pkg::MMSC_CLK_EXT:   tick = 1'b0;
      mmsc_pkg::MMSC_CLK_TIMER: tick = i_timer_toggle_output != st_reg.tmr_prev;
      mmsc_pkg::MMSC_CLK_DIV16,
      mmsc_pkg::MMSC_CLK_DIV8:  tick = st_reg.div == half;
    endcase
    if (internal_clk)
    begin
      rise_evt = tick && !st_reg.sck_lvl && st_reg.active;
      // an idle tick counts as a falling edge so busy can end without a transfer
      fall_evt = tick && (st_reg.sck_lvl || !st_reg.active);
    end
    else
    begin
      rise_evt = st_reg.sync2[0] && !st_reg.sck_prev;
      fall_evt = !st_reg.sync2[0] && st_reg.sck_prev;
    end
    // second stages only: 0 sck, 1 serial in, 2 line a, 3 line b
    if (mode_now == mmsc_pkg::MMSC_THREE_WIRE)
      in_bit = st_reg.sync2[1];
    else
      in_bit = st_reg.mode[`MMSC_B_PINSEL] ? st_reg.sync2[3] : st_reg.sync2[2];
  end

  // lsb-first only honoured in three-wire mode
  always_comb
  begin
    if (st_reg.lsb_first && mode_now == mmsc_pkg::MMSC_THREE_WIRE)
    begin
      out_bit = st_reg.sreg[0];
      shifted = {in_bit, st_reg.sreg[7:1]};
    end
    else
    begin
      out_bit = st_reg.sreg[7];
      shifted = {st_reg.sreg[6:0], in_bit};
    end
    addr_match = st_reg.slave_address_reg == st_reg.sreg;
    shifted_match = st_reg.slave_address_reg == shifted;
    setup = psel && !penable;
    wr_acc = psel && penable && pready && pwrite;
    mapped = paddr == `MMSC_OFF_MODE || paddr == `MMSC_OFF_SHIFT || paddr == `MMSC_OFF_SVA
          || paddr == `MMSC_OFF_CTRL || paddr == `MMSC_OFF_BITS;
  end

  always_comb
  begin
    st_next = st_reg;
    if (wr_acc && paddr == `MMSC_OFF_CTRL && pwdata[`MMSC_C_DONE])
      st_next.done = 1'b0;                        // a done set further down wins
    st_next.sync1 = {i_bus_data_line_b, i_bus_data_line_a, i_serial_in_pin, i_shift_clock_pin};
    st_next.sync2 = st_reg.sync1;
    st_next.sck_prev = st_reg.sync2[0];
    st_next.tmr_prev = i_timer_toggle_output;
    st_next.div = (tick || !enabled) ? 4'h0 : st_reg.div + 4'h1;
    // shifting and counting
    if (!enabled)
    begin
      st_next.active = 1'b0;
      st_next.cnt = 3'h0;
      st_next.sck_lvl = 1'b1;
    end
    else if (st_reg.active)
    begin
      if (internal_clk && tick)
        st_next.sck_lvl = !st_reg.sck_lvl;
      if (rise_evt)
      begin
        st_next.sreg = shifted;
        st_next.cnt = st_reg.cnt + 3'h1;
        if (st_reg.cnt == `MMSC_LAST_BIT)
        begin
          st_next.active = 1'b0;
          // wake only means something in bus mode
          if (!st_reg.mode[`MMSC_B_WAKE] || mode_now != mmsc_pkg::MMSC_BUS)
            st_next.done = 1'b1;
          else if (shifted_match)
            st_next.done = 1'b1;
          if (st_reg.busy_en && mode_now == mmsc_pkg::MMSC_BUS)
            st_next.busy = 1'b1;
        end
      end
    end
    // busy drops only at a falling clock once release is asked, wake has no say
    if (st_reg.busy && !st_reg.busy_en && fall_evt)
      st_next.busy = 1'b0;
    // register writes
    if (wr_acc)
    begin
      unique case (paddr)
        `MMSC_OFF_MODE:
        begin
          st_next.mode = pwdata[7:0];
          st_next.mode[`MMSC_B_MATCH] = 1'b0;
        end
        `MMSC_OFF_SHIFT:
        begin
          st_next.sreg = pwdata[7:0];
          st_next.active = enabled;
          st_next.cnt = 3'h0;
          st_next.sck_lvl = 1'b1;
          st_next.div = 4'h0;
        end
        `MMSC_OFF_SVA: st_next.slave_address_reg = pwdata[7:0];
        `MMSC_OFF_CTRL:
        begin
          st_next.busy_en = pwdata[`MMSC_C_BUSYEN];
          st_next.lsb_first = pwdata[`MMSC_C_LSBF];
          st_next.force_clk_lo = pwdata[`MMSC_C_FCLK];
          st_next.force_dat_lo = pwdata[`MMSC_C_FDAT];
        end
        `MMSC_OFF_BITS:
        begin
          // per-bit access to the top bits; mask in 15:8, bit 6 never written
          if (pwdata[8 + `MMSC_B_ENABLE])
            st_next.mode[`MMSC_B_ENABLE] = pwdata[`MMSC_B_ENABLE];
          if (pwdata[8 + `MMSC_B_WAKE])
            st_next.mode[`MMSC_B_WAKE] = pwdata[`MMSC_B_WAKE];
        end
        default: ;
      endcase
    end
    // read data captured in setup, answered in access
    st_next.ack = setup;
    st_next.err = setup && !mapped;
    if (setup)
    begin
      st_next.rdata = 32'h0;
      unique case (paddr)
        `MMSC_OFF_MODE:
        begin
          st_next.rdata[7:0] = st_reg.mode;
          st_next.rdata[`MMSC_B_MATCH] = addr_match;
        end
        `MMSC_OFF_SHIFT: st_next.rdata[7:0] = st_reg.sreg;
        `MMSC_OFF_SVA:   st_next.rdata[7:0] = st_reg.slave_address_reg;
        `MMSC_OFF_CTRL:
          st_next.rdata[6:0] = {st_reg.busy, st_reg.active, st_reg.force_dat_lo,
                                st_reg.force_clk_lo, st_reg.lsb_first, st_reg.busy_en,
                                st_reg.done};
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_reg <= '0;
      st_reg.mode <= `MMSC_MODE_RESET;
      st_reg.sck_lvl <= 1'b1;
    end
    else
      st_reg <= st_next;
  end
  // pins: open drain lines only ever pull low
  logic dat_low;
  logic bus_like;
  always_comb
  begin
    bus_like = mode_now == mmsc_pkg::MMSC_BUS || mode_now == mmsc_pkg::MMSC_TWO_WIRE;
    if (st_reg.busy)
      dat_low = 1'b1;
    else if (mode_now == mmsc_pkg::MMSC_BUS && st_reg.mode[`MMSC_B_WAKE])
      dat_low = 1'b0;
    else if (mode_now == mmsc_pkg::MMSC_TWO_WIRE && st_reg.force_dat_lo)
      dat_low = 1'b1;
    else
      dat_low = st_reg.active && !out_bit;
    o_shift_clock_pin = st_reg.sck_lvl
                     && !(mode_now == mmsc_pkg::MMSC_TWO_WIRE && st_reg.force_clk_lo);
    o_shift_clock_pin_oe = internal_clk;
    o_serial_out_pin = out_bit;
    o_serial_out_pin_oe = mode_now == mmsc_pkg::MMSC_THREE_WIRE;
    o_bus_data_line_a = 1'b0;
    o_bus_data_line_b = 1'b0;
    o_bus_data_line_a_oe = bus_like && !st_reg.mode[`MMSC_B_PINSEL] && dat_low;
    o_bus_data_line_b_oe = bus_like && st_reg.mode[`MMSC_B_PINSEL] && dat_low;
    o_pins_to_port = !enabled;
    o_transfer_done_request = st_reg.done;
    prdata = st_reg.rdata;
    pready = st_reg.ack && psel && penable;
    pslverr = st_reg.err && psel && penable;
  end
  sequence seq_start_int;
    wr_acc && paddr == `MMSC_OFF_SHIFT && enabled && clk_sel[1];  // timer pace is set outside
  endsequence
  sequence seq_last_rise;
    st_reg.active && rise_evt && st_reg.cnt == `MMSC_LAST_BIT;
  endsequence
  chk_bit6_ignored: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    wr_acc && paddr == `MMSC_OFF_MODE |=> !st_reg.mode[`MMSC_B_MATCH])
    else $error("bit 6 of mode control stored a written value");
  chk_done_eighth: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    seq_last_rise ##0 !st_reg.mode[`MMSC_B_WAKE] |=> st_reg.done && !st_reg.active)
    else $error("eighth clock did not complete the transfer");
  chk_halt_clears: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !enabled |-> o_pins_to_port
                 ##1 st_reg.cnt == 3'h0 && !st_reg.active && !$rose(st_reg.done))
    else $error("halt did not clear the counter");
  chk_halt_pins: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !enabled && !st_reg.busy |-> !o_serial_out_pin_oe && !o_bus_data_line_a_oe
                                 && !o_bus_data_line_b_oe)
    else $error("pins driven while halted");
  chk_match_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    setup && paddr == `MMSC_OFF_MODE |=> prdata[`MMSC_B_MATCH] == $past(addr_match))
    else $error("match flag read wrong");
  chk_wake_release: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mode_now == mmsc_pkg::MMSC_BUS && st_reg.mode[`MMSC_B_WAKE] && !st_reg.busy
    |-> !o_bus_data_line_a_oe && !o_bus_data_line_b_oe)
    else $error("data line driven in wake state");
  chk_busy_hold: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    st_reg.busy && !fall_evt |=> st_reg.busy)
    else $error("busy ended without a falling clock");
  chk_int_pulses: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    seq_start_int ##1 enabled [*3] |-> ##[1:40] !o_shift_clock_pin || !enabled)
    else $error("no clock pulse after start");
  chk_three_out: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    mode_now == mmsc_pkg::MMSC_THREE_WIRE |-> o_serial_out_pin
      == (st_reg.lsb_first ? st_reg.sreg[0] : st_reg.sreg[7]))
    else $error("wrong bit order on serial out");
  chk_ext_input: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    clk_sel == mmsc_pkg::MMSC_CLK_EXT |-> !o_shift_clock_pin_oe)
    else $error("clock pin driven with external clock");
endmodule : mmsc_channel

// ===== bench/mmsc_peer_model.sv
// external three-wire peripheral that faces the serial channel
// assumes the clock line idles high; the channel moves its output on the rise,
// so the peer takes the channel's bit at the fall, where it has stood half a period
`timescale 1ns/1ps
module mmsc_peer_model (
  input  wire logic       i_sck,
  input  wire logic       i_data,
  input  wire logic       i_load,
  input  wire logic [7:0] i_tx_byte,
  output logic            o_data,
  output logic      [7:0] o_rx_byte,
  output logic      [3:0] o_rises
);
  logic [7:0] tx_reg;
  // msb first from the peer side
  assign o_data = tx_reg[7];
  // shift only after a rise, so the first fall keeps bit 7; fill with changing bits
  always @(posedge i_load or negedge i_sck)
    if (i_load)
      tx_reg <= i_tx_byte;
    else
    begin
      o_rx_byte <= {o_rx_byte[6:0], i_data};
      if (o_rises != 4'h0)
        tx_reg <= {tx_reg[6:0], ~tx_reg[7]};
    end
  always @(posedge i_sck or posedge i_load)
    if (i_load)
      o_rises <= 4'h0;
    else
      o_rises <= o_rises + 4'h1;
endmodule : mmsc_peer_model

// ===== bench/tb_top.sv
// self-checking bench of the serial channel over apb with a three-wire peer
// assumes an idle-high clock line with a pull-up; the peer also pulls open-drain line a
`timescale 1ns/1ps
`include "mmsc_consts.svh"
module tb_top;
  logic        clk = 1'b0, rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, peer_load = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err_seen;
  logic        sck_o, sck_oe, so_o, so_oe, sa_oe, sb_oe, port, done, peer_d;
  logic [7:0]  peer_tx = 8'h00, peer_rx;
  logic [3:0]  rises;
  int          err_count = 0, samples_checked = 0;
  wire         sck_w = sck_oe ? sck_o : 1'b1;
  initial forever #2.5 clk = ~clk;
  mmsc_channel u_dut (.i_ref_clk(clk), .i_rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_timer_toggle_output(1'b0), .i_shift_clock_pin(sck_w),
    .o_shift_clock_pin(sck_o), .o_shift_clock_pin_oe(sck_oe), .o_serial_out_pin(so_o),
    .o_serial_out_pin_oe(so_oe), .i_serial_in_pin(peer_d), .i_bus_data_line_a(~sa_oe & peer_d),
    .o_bus_data_line_a(), .o_bus_data_line_a_oe(sa_oe), .i_bus_data_line_b(~sb_oe),
    .o_bus_data_line_b(), .o_bus_data_line_b_oe(sb_oe), .o_pins_to_port(port),
    .o_transfer_done_request(done));
  mmsc_peer_model u_peer (.i_sck(sck_w), .i_data(so_oe ? so_o : 1'b1), .i_load(peer_load),
    .i_tx_byte(peer_tx), .o_data(peer_d), .o_rx_byte(peer_rx), .o_rises(rises));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task stop_test;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test
  // one apb transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    // no answer time assumed: only the watchdog ends a wait that never answers
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    // outputs launched by the write edge settle before callers look at them
    @(negedge clk);
  endtask : apb
  task automatic start_xfer(input logic [7:0] peer_byte, input logic [7:0] dev_byte);
    int n;
    @(posedge clk);
    peer_tx <= peer_byte; peer_load <= 1'b1;
    @(posedge clk);
    peer_load <= 1'b0;
    apb(1'b1, `MMSC_OFF_SHIFT, {24'h0, dev_byte});
    n = 0;
    while (done !== 1'b1 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
  endtask : start_xfer
  task t_reset_regs;
    apb(1'b0, `MMSC_OFF_MODE, 32'h0);
    check("mode after reset", rd & 32'hbf, 32'h0);
    check("port after reset", port, 1'b1);
    apb(1'b0, 12'h0f0, 32'h0);
    check("unmapped error", err_seen, 1'b1);
    apb(1'b1, `MMSC_OFF_SVA, 32'h11);
    apb(1'b1, `MMSC_OFF_MODE, 32'h40);
    apb(1'b0, `MMSC_OFF_MODE, 32'h0);
    check("match bit write ignored", rd, 32'h0);
  endtask : t_reset_regs
  task t_halted;
    apb(1'b1, `MMSC_OFF_MODE, 32'h03);
    check("internal clock drives pin", sck_oe, 1'b1);
    start_xfer(8'h99, 8'h55);
    check("no clocks while halted", rises, 4'h0);
    check("no done while halted", done, 1'b0);
    check("pins to port", port, 1'b1);
  endtask : t_halted
  task t_msb_first;
    apb(1'b1, `MMSC_OFF_SVA, 32'h3c);
    apb(1'b1, `MMSC_OFF_BITS, 32'h8080);
    check("port released", port, 1'b0);
    start_xfer(8'h3c, 8'ha5);
    check("eight clocks", rises, 4'h8);
    check("peer got msb first", peer_rx, 8'ha5);
    check("done request", done, 1'b1);
    apb(1'b0, `MMSC_OFF_SHIFT, 32'h0);
    check("received byte", rd, 32'h3c);
    apb(1'b0, `MMSC_OFF_MODE, 32'h0);
    check("mode with match", rd, 32'hc3);
    apb(1'b0, `MMSC_OFF_CTRL, 32'h0);
    check("done status", rd[0], 1'b1);
  endtask : t_msb_first
  task t_lsb_first;
    apb(1'b1, `MMSC_OFF_CTRL, 32'h05);
    check("done cleared", done, 1'b0);
    start_xfer(8'hc5, 8'h1e);
    check("eight clocks lsb", rises, 4'h8);
    check("peer got lsb first", peer_rx, 8'h78);
    apb(1'b0, `MMSC_OFF_SHIFT, 32'h0);
    check("received lsb first", rd, 32'ha3);
    apb(1'b0, `MMSC_OFF_MODE, 32'h0);
    check("mode without match", rd, 32'h83);
  endtask : t_lsb_first
  // bus mode on line a with wake set: the channel only listens
  task t_bus_wake;
    apb(1'b1, `MMSC_OFF_CTRL, 32'h01);
    apb(1'b1, `MMSC_OFF_MODE, 32'hab);
    check("line released in wake", sa_oe, 1'b0);
    start_xfer(8'h5a, 8'h00);
    check("eight clocks bus", rises, 4'h8);
    check("no done on other address", done, 1'b0);
    apb(1'b0, `MMSC_OFF_SHIFT, 32'h0);
    check("bus byte received", rd, 32'h5a);
    start_xfer(8'h3c, 8'h00);
    check("done on own address", done, 1'b1);
    apb(1'b0, `MMSC_OFF_MODE, 32'h0);
    check("match after bus byte", rd, 32'heb);
  endtask : t_bus_wake
  // busy after a bus transfer, its release, then two-wire forced levels
  task t_busy_two_wire;
    int n;
    apb(1'b1, `MMSC_OFF_BITS, 32'h2000);
    apb(1'b1, `MMSC_OFF_CTRL, 32'h03);
    start_xfer(8'hff, 8'hff);
    check("done without wake", done, 1'b1);
    check("busy pulls line", sa_oe, 1'b1);
    apb(1'b1, `MMSC_OFF_BITS, 32'h2020);
    check("wake keeps busy", sa_oe, 1'b1);
    apb(1'b1, `MMSC_OFF_BITS, 32'h2000);
    apb(1'b1, `MMSC_OFF_CTRL, 32'h00);
    n = 0;
    while (sa_oe !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    check("line high before wake", sa_oe, 1'b0);
    apb(1'b1, `MMSC_OFF_BITS, 32'h2020);
    check("wake after release", sa_oe, 1'b0);
    apb(1'b1, `MMSC_OFF_MODE, 32'h9f);
    apb(1'b1, `MMSC_OFF_CTRL, 32'h18);
    check("forced clock low", sck_w, 1'b0);
    check("line b forced low", sb_oe, 1'b1);
    check("line a plain input", sa_oe, 1'b0);
  endtask : t_busy_two_wire
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset_regs();
    t_halted();
    t_msb_first();
    t_lsb_first();
    t_bus_wake();
    t_busy_two_wire();
    stop_test();
  end
  // the whole run needs a few thousand cycles
  initial
  begin
    #100000;
    err_count++;
    stop_test();
  end
endmodule : tb_top
